// ==== bench/interrupt_priority_and_stop_wakeup_tb_top.sv ====
// Self-checking bench of the interrupt controller and stop-mode wake logic.
// Assumes iwk_core_sim plays the core and clock control.
`timescale 1ns/10ps
module interrupt_priority_and_stop_wakeup_tb_top;
    import iwk_pkg::*;
    logic aclk;
    logic aresetn;
    iwk_axi_req_t axi_in;
    iwk_axi_rsp_t axi_out;
    logic [31:0] irq_src;
    logic irq, core_irq_ack, core_irq_done, core_wake, clk_running, clk_wake_req;
    iwk_core_req_t core_req;
    iwk_pwr_mode_t pwr_mode;
    iwk_wake_src_t wake_src;
    iwk_wake_qual_t wake_qual;
    logic hold_done, clk_stop, seen, gated;
    logic [63:0] pf;
    logic [31:0] d;
    logic [1:0] rsp;
    int n_fail, comparisons, seed, cyc, n, v;

    iwk_ctrl dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .axi_in(axi_in),
        .axi_out(axi_out), .irq_src(irq_src), .irq(irq), .core_req(core_req),
        .core_irq_ack(core_irq_ack), .core_irq_done(core_irq_done),
        .core_wake(core_wake), .pwr_mode(pwr_mode), .wake_src(wake_src),
        .wake_qual(wake_qual), .clk_running(clk_running), .clk_wake_req(clk_wake_req));
    iwk_core_sim partner (.aclk(aclk), .aresetn(aresetn), .core_req(core_req),
        .clk_wake_req(clk_wake_req), .hold_done(hold_done), .clk_stop(clk_stop),
        .core_irq_ack(core_irq_ack), .core_irq_done(core_irq_done),
        .clk_running(clk_running));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Run ceiling well above the expected few thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        axi_in.awvalid <= 1'b1;
        axi_in.awaddr <= a;
        axi_in.wvalid <= 1'b1;
        axi_in.wdata <= wd;
        axi_in.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_in.awvalid && axi_out.awready) begin
                aw = 1'b1;
                axi_in.awvalid <= 1'b0;
            end
            if (axi_in.wvalid && axi_out.wready) begin
                w = 1'b1;
                axi_in.wvalid <= 1'b0;
            end
        end while (!(aw && w));
        do @(posedge aclk); while (axi_out.bvalid !== 1'b1);
        r = axi_out.bresp;
        axi_in.bready <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
              input logic [1:0] er);
        @(posedge aclk);
        axi_in.arvalid <= 1'b1;
        axi_in.araddr <= a;
        axi_in.rready <= 1'b1;
        do @(posedge aclk); while (!(axi_in.arvalid && axi_out.arready));
        axi_in.arvalid <= 1'b0;
        while (axi_out.rvalid !== 1'b1) @(posedge aclk);
        axi_in.rready <= 1'b0;
        chk(axi_out.rdata & m, e);
        chk(axi_out.rresp, er);
    endtask

    task wait_offer(input int lim);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (core_req.valid !== 1'b1 && n < lim);
        // A run-out limit must not pass on a stale vector that is still shown
        if (lim > 0) begin
            chk(core_req.valid, 1);
        end
    endtask

    initial begin
        seed = 14;
        n_fail = 0;
        comparisons = 0;
        cyc = 0;
        aresetn = 1'b0;
        axi_in = '0;
        axi_in.wstrb = 4'hf;
        irq_src = '0;
        pwr_mode = IWK_RUN;
        wake_src = '0;
        wake_qual = '0;
        hold_done = 1'b0;
        clk_stop = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 28; a += 4) begin
            rchk(8'(a), 32'hffffffff, 32'h0, RESP_OKAY);
        end
        rchk(8'h1c, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'h1, rsp);
        chk(rsp, RESP_SLVERR);
        wr(OFS_ACTIVE, 32'hffffffff, rsp);
        rchk(OFS_ACTIVE, 32'hffffffff, 32'h0, RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            d = $random(seed);
            pf[32*k +: 32] = d;
            wr(8'(OFS_PRIO0 + 4 * k), d, rsp);
            rchk(8'(OFS_PRIO0 + 4 * k), 32'hffffffff, d, RESP_OKAY);
        end
        wr(OFS_ENABLE, 32'hffffffff, rsp);
        for (int i = 0; i < 32; i++) begin
            v = (i * 13) % 32;
            pwr_mode <= (i % 3 == 0) ? IWK_RUN : (i % 3 == 1) ? IWK_WAIT : IWK_VERY_LOW_POWER_WAIT;
            @(posedge aclk);
            irq_src[v] <= 1'b1;
            wait_offer(40);
            chk(n <= ENTRY_MAX_CYC, 1);
            chk(core_req.vec, v);
            chk(core_req.prio, pf[2*v +: 2]);
            chk(irq, 1);
            chk(core_wake, i % 3 != 0);
            irq_src[v] <= 1'b0;
            repeat (16) @(posedge aclk);
        end
        pwr_mode <= IWK_RUN;
        // Source 1 and 3 share level 2, source 2 is level 0
        wr(OFS_PRIO0, 32'h88, rsp);
        hold_done <= 1'b1;
        irq_src[1] <= 1'b1;
        wait_offer(40);
        chk(core_req.vec, 1);
        repeat (6) @(posedge aclk);
        irq_src[3] <= 1'b1;
        seen = 1'b0;
        repeat (20) begin
            @(posedge aclk);
            seen = seen | (core_req.valid === 1'b1);
        end
        chk(seen, 0);
        irq_src[2] <= 1'b1;
        wait_offer(40);
        chk(n <= ENTRY_MAX_CYC, 1);
        chk({core_req.vec, core_req.prio}, {5'd2, 2'd0});
        repeat (6) @(posedge aclk);
        rchk(OFS_ACTIVE, 32'h8000000f, 32'h5, RESP_OKAY);
        hold_done <= 1'b0;
        wait_offer(60);
        chk(core_req.vec, 3);
        irq_src[3:1] <= 3'h0;
        repeat (30) @(posedge aclk);
        wr(OFS_ENABLE, 32'h0, rsp);
        irq_src[9] <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(irq, 0);
        rchk(OFS_PEND, 32'hffffffff, 32'h200, RESP_OKAY);
        wr(OFS_PEND, 32'h200, rsp);
        rchk(OFS_PEND, 32'hffffffff, 32'h0, RESP_OKAY);
        irq_src[9] <= 1'b0;
        clk_stop <= 1'b1;
        for (int b = 0; b < 18; b++) begin
            for (int q = 0; q < 2; q++) begin
                gated = (b == 0) || (b == 4) || (b >= 10);
                wr(OFS_WAKE_EN, (q == 1 && !gated) ? 32'h0 : 32'h1 << b, rsp);
                wake_qual <= (q == 1) ? '0 : '1;
                pwr_mode <= b[0] ? IWK_VERY_LOW_POWER_STOP : IWK_STOP;
                @(posedge aclk);
                wake_src <= 18'(1 << b);
                wait_offer(0);
                seen = 1'b0;
                repeat (12) begin
                    @(posedge aclk);
                    seen = seen | (clk_wake_req === 1'b1);
                end
                wake_src <= '0;
                chk(seen, q == 0);
                n = 0;
                while (clk_wake_req !== 1'b0 && n < 30) begin
                    @(posedge aclk);
                    n++;
                end
                chk(clk_wake_req, 0);
                pwr_mode <= IWK_RUN;
                d = (q == 0) ? 32'h1 << b : 32'h0;
                rchk(OFS_WAKE_STAT, 32'hffffffff, d, RESP_OKAY);
                wr(OFS_WAKE_STAT, d, rsp);
            end
        end
        conclude();
    end
endmodule

// ==== bench/iwk_core_sim.sv ====
// Behavioural processor core and clock control facing the interrupt block.
// Assumes the bench drives hold_done and clk_stop by non-blocking assignment.
`timescale 1ns/10ps
module iwk_core_sim
    import iwk_pkg::*;
(
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // From the block
    input iwk_pkg::iwk_core_req_t core_req,
    input logic clk_wake_req,
    // Bench controls
    input logic hold_done,
    input logic clk_stop,
    // To the block
    output logic core_irq_ack,
    output logic core_irq_done,
    output logic clk_running
);
    int depth;
    int gap;
    logic [1:0] wake_dly;

    always @(posedge aclk) begin
        if (!aresetn) begin
            core_irq_ack <= 1'b0;
            core_irq_done <= 1'b0;
            wake_dly <= 2'h0;
            clk_running <= 1'b1;
            depth = 0;
            gap = 0;
        end else begin
            // Takes whatever vector stands at the ack edge
            core_irq_ack <= core_req.valid && !core_irq_ack;
            if (core_irq_ack && core_req.valid) begin
                depth++;
            end
            core_irq_done <= 1'b0;
            if (depth > 0 && !hold_done) begin
                gap++;
            end
            if (gap == 6) begin
                core_irq_done <= 1'b1;
                depth--;
                gap = 0;
            end
            // Clocks return three cycles late, like a slow oscillator start
            wake_dly <= {wake_dly[0], clk_wake_req};
            clk_running <= !clk_stop || wake_dly[1];
        end
    end
endmodule

// ==== hw/iwk_ctrl.sv ====
// Nested vectored interrupt controller with stop-mode wake detector.
// Assumes peripheral request lines also feed irq_src so wake causes pend.
// Notes on behaviour
// - Nesting with four distinct priority levels
// - Two-bit priority field per source
// - Thirty-two vectors, one per request line
// - Request to handler entry within fifteen cycles
// - Pending enabled interrupt wakes wait modes
// - Clockless stop detection asks clocks to restart
// - Waking request is pending after clock restart
// - Wakes from stop and very-low-power stop
// - Reset pin wakes only with low-power filter clock
// - Voltage detect and warning wake from stop
// - Any enabled pin interrupt wakes from stop
// - Converter wakes only on internal clock
// - Comparator wakes in normal and triggered operation
// - Clocked serial, timer, touch, flexible units wake
// - Clock alarm or seconds interrupt wakes
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module iwk_ctrl (
    // Clock, reset, enable
    input logic aclk,
    input logic aresetn,
    input logic ce,
    // AXI4-Lite slave
    input iwk_pkg::iwk_axi_req_t axi_in,
    output iwk_pkg::iwk_axi_rsp_t axi_out,
    // Interrupt lines and summary output
    input logic [31:0] irq_src,
    output logic irq,
    // Core side
    output iwk_pkg::iwk_core_req_t core_req,
    input logic core_irq_ack,
    input logic core_irq_done,
    output logic core_wake,
    // Power and clock control
    input iwk_pkg::iwk_pwr_mode_t pwr_mode,
    input iwk_pkg::iwk_wake_src_t wake_src,
    input iwk_pkg::iwk_wake_qual_t wake_qual,
    input logic clk_running,
    output logic clk_wake_req
);
    import iwk_pkg::*;
    typedef struct packed {
        iwk_axi_rsp_t axi;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] enable;
        logic [31:0] pend;
        logic [63:0] prio;
        logic [17:0] wake_en;
        logic [17:0] wake_stat;
        logic [31:0] src_q;
        logic [3:0] active;
        iwk_core_req_t req;
        logic [1:0] quiet;
        logic irq;
        logic core_wake;
        logic wake_taken;
    } iwk_top_st_t;
    iwk_top_st_t st, next_st;

    logic best_valid;
    logic [4:0] best_id;
    logic [1:0] best_prio;
    logic det_valid;
    logic [17:0] det_cause;
    logic [31:0] rise_w;
    logic stop_w;
    logic ack_w;

    assign rise_w = irq_src & ~st.src_q;
    assign stop_w = (pwr_mode == IWK_STOP) || (pwr_mode == IWK_VERY_LOW_POWER_STOP);
    assign ack_w = core_irq_ack && st.req.valid;

    iwk_prio_arb u_arb (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .req(st.pend & st.enable),
        .prio_flat(st.prio),
        .best_valid(best_valid),
        .best_id(best_id),
        .best_prio(best_prio)
    );

    iwk_wake_det u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .stop(stop_w),
        .wake_en(st.wake_en),
        .src(wake_src),
        .qual(wake_qual),
        .clk_running(clk_running),
        .taken(st.wake_taken),
        .wake_req(clk_wake_req),
        .cause_valid(det_valid),
        .cause(det_cause)
    );

    always_comb begin
        logic [31:0] clr;
        logic [31:0] ack_clr;
        logic [17:0] wclr;
        logic [31:0] rd;
        logic rd_ok;
        logic [1:0] cur;
        clr = '0;
        ack_clr = '0;
        wclr = '0;
        rd = '0;
        rd_ok = 1'b1;
        cur = lowest_set(st.active);
        next_st = st;
        if (ce) begin
            // Write channel: address and data may arrive in either order
            if (axi_in.awvalid && st.axi.awready) begin
                next_st.aw_got = 1'b1;
                next_st.waddr = axi_in.awaddr;
            end
            if (axi_in.wvalid && st.axi.wready) begin
                next_st.w_got = 1'b1;
                next_st.wdata = axi_in.wdata;
                next_st.wstrb = axi_in.wstrb;
            end
            if (st.aw_got && st.w_got && !st.axi.bvalid) begin
                next_st.aw_got = 1'b0;
                next_st.w_got = 1'b0;
                next_st.axi.bvalid = 1'b1;
                next_st.axi.bresp = RESP_OKAY;
                case (st.waddr)
                    OFS_ENABLE: next_st.enable = apply_strb(st.enable, st.wdata, st.wstrb);
                    OFS_PEND: clr = apply_strb(32'h0, st.wdata, st.wstrb);
                    OFS_PRIO0: next_st.prio[31:0] = apply_strb(st.prio[31:0], st.wdata, st.wstrb);
                    OFS_PRIO1: next_st.prio[63:32] = apply_strb(st.prio[63:32], st.wdata,
                                                               st.wstrb);
                    OFS_ACTIVE: begin
                    end
                    OFS_WAKE_EN: next_st.wake_en = 18'(apply_strb({14'h0, st.wake_en},
                                                                  st.wdata, st.wstrb));
                    OFS_WAKE_STAT: wclr = 18'(apply_strb(32'h0, st.wdata, st.wstrb));
                    default: next_st.axi.bresp = RESP_SLVERR;
                endcase
            end
            if (st.axi.bvalid && axi_in.bready) begin
                next_st.axi.bvalid = 1'b0;
            end
            next_st.axi.awready = !next_st.aw_got && !next_st.axi.bvalid;
            next_st.axi.wready = !next_st.w_got && !next_st.axi.bvalid;

            // Read channel
            case (axi_in.araddr)
                OFS_ENABLE: rd = st.enable;
                OFS_PEND: rd = st.pend;
                OFS_PRIO0: rd = st.prio[31:0];
                OFS_PRIO1: rd = st.prio[63:32];
                OFS_ACTIVE: rd = {st.req.valid, 17'h0, st.req.vec, st.req.prio, 3'h0, st.active};
                OFS_WAKE_EN: rd = {14'h0, st.wake_en};
                OFS_WAKE_STAT: rd = {14'h0, st.wake_stat};
                default: rd_ok = 1'b0;
            endcase
            if (axi_in.arvalid && st.axi.arready) begin
                next_st.axi.rvalid = 1'b1;
                next_st.axi.rdata = rd;
                next_st.axi.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (st.axi.rvalid && axi_in.rready) begin
                next_st.axi.rvalid = 1'b0;
            end
            next_st.axi.arready = !next_st.axi.rvalid;

            // Nesting: one bit per active priority level
            if (core_irq_done && st.active != 4'h0) begin
                next_st.active[cur] = 1'b0;
            end
            if (ack_w) begin
                next_st.active[st.req.prio] = 1'b1;
                ack_clr[st.req.vec] = 1'b1;
                // Arbiter lags the pending register, so hold off re-offering
                next_st.quiet = QUIET_CYC;
            end else if (st.quiet != 2'h0) begin
                next_st.quiet = st.quiet - 2'h1;
            end

            // Rising edges pend; a new edge beats a same-cycle clear
            next_st.src_q = irq_src;
            next_st.pend = (st.pend & ~clr & ~ack_clr) | rise_w;

            next_st.req.valid = best_valid && !ack_w && st.quiet == 2'h0 &&
                (st.active == 4'h0 || best_prio < cur);
            next_st.req.vec = best_id;
            next_st.req.prio = best_prio;

            next_st.irq = (next_st.pend & next_st.enable) != 32'h0;
            next_st.core_wake = (pwr_mode == IWK_WAIT || pwr_mode == IWK_VERY_LOW_POWER_WAIT) &&
                (st.pend & st.enable) != 32'h0;

            // Wake causes land in sticky status once clocks run
            next_st.wake_taken = det_valid && !st.wake_taken;
            next_st.wake_stat = (st.wake_stat & ~wclr) |
                (next_st.wake_taken ? det_cause : 18'h0);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.enable <= RST_ENABLE;
            st.prio <= RST_PRIO;
            st.wake_en <= RST_WAKE_EN;
        end else begin
            st <= next_st;
        end
    end

    assign axi_out = st.axi;
    assign irq = st.irq;
    assign core_req = st.req;
    assign core_wake = st.core_wake;

    // Cycles an enabled request waits with no handler running
    logic [4:0] entry_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            entry_cnt <= 5'h0;
        end else if ((st.pend & st.enable) != 32'h0 && st.active == 4'h0 && !st.req.valid) begin
            entry_cnt <= entry_cnt + 5'h1;
        end else begin
            entry_cnt <= 5'h0;
        end
    end

    AST_NEST_PREEMPT: assert property (@(posedge aclk) disable iff (!aresetn)
        core_req.valid |-> st.active == 4'h0 || core_req.prio < lowest_set(st.active))
        else $error("offered request does not outrank running handler");
    AST_PEND_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> (st.pend & ~$past(st.pend) & ~$past(rise_w)) == 32'h0)
        else $error("pending bit set without its line rising");
    AST_ENTRY_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |-> entry_cnt < 5'(ENTRY_MAX_CYC))
        else $error("interrupt entry took too long");
    AST_WAIT_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && (pwr_mode == IWK_WAIT || pwr_mode == IWK_VERY_LOW_POWER_WAIT) &&
        (st.pend & st.enable) != 32'h0 |=> core_wake)
        else $error("pending interrupt did not wake core from wait");
    AST_WAKE_SEEN: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && det_valid && !st.wake_taken |=> (st.wake_stat & $past(det_cause)) == $past(det_cause))
        else $error("wake cause not recorded after clock restart");
endmodule

// ==== hw/iwk_pkg.sv ====
// Shared constants, types and helpers of the interrupt and wake-up block.
// Assumes a 32-bit AXI4-Lite register bus and a single clock.
package iwk_pkg;
    localparam int NUM_SRC = 32;
    localparam int NUM_LVL = 4;
    localparam int NUM_WAKE = 18;
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_PEND = 8'h04;
    localparam logic [7:0] OFS_PRIO0 = 8'h08;
    localparam logic [7:0] OFS_PRIO1 = 8'h0c;
    localparam logic [7:0] OFS_ACTIVE = 8'h10;
    localparam logic [7:0] OFS_WAKE_EN = 8'h14;
    localparam logic [7:0] OFS_WAKE_STAT = 8'h18;
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [63:0] RST_PRIO = 64'h0;
    localparam logic [17:0] RST_WAKE_EN = 18'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ENTRY_MAX_CYC = 15;
    localparam logic [1:0] QUIET_CYC = 2'h2;

    typedef enum logic [4:0] {
        IWK_RUN = 5'h01,
        IWK_WAIT = 5'h02,
        IWK_VERY_LOW_POWER_WAIT = 5'h04,
        IWK_STOP = 5'h08,
        IWK_VERY_LOW_POWER_STOP = 5'h10
    } iwk_pwr_mode_t;

    typedef enum logic [2:0] {
        WK_IDLE = 3'h1,
        WK_HOLD = 3'h2,
        WK_GIVE = 3'h4
    } iwk_wake_state_t;

    // Bit order equals the wake status register layout, bit 0 last
    typedef struct packed {
        logic [7:0] per_irq;
        logic usb;
        logic nmi;
        logic rtc_sec;
        logic rtc_alarm;
        logic cmp;
        logic adc;
        logic pin_irq;
        logic lvw;
        logic low_voltage_detect;
        logic rst_pin;
    } iwk_wake_src_t;

    typedef struct packed {
        logic [7:0] per_clk_on;
        logic adc_int_clk;
        logic rst_flt_lpo;
    } iwk_wake_qual_t;

    typedef struct packed {
        logic valid;
        logic [4:0] vec;
        logic [1:0] prio;
    } iwk_core_req_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } iwk_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } iwk_axi_rsp_t;

    function automatic logic [1:0] lowest_set(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h3;
        for (int i = 3; i >= 0; i--) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] prio_of(input logic [63:0] f, input logic [4:0] i);
        return f[2*i +: 2];
    endfunction

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction
endpackage

// ==== hw/iwk_prio_arb.sv ====
// Priority arbiter: picks the most urgent enabled pending source.
// Assumes requests and priority fields come from registers of the caller.
`timescale 1ns/10ps
module iwk_prio_arb (
    // Clock, reset, enable
    input logic aclk,
    input logic aresetn,
    input logic ce,
    // Requests and priority fields
    input logic [31:0] req,
    input logic [63:0] prio_flat,
    // Winner, registered
    output logic best_valid,
    output logic [4:0] best_id,
    output logic [1:0] best_prio
);
    import iwk_pkg::*;
    typedef struct packed {
        logic valid;
        logic [4:0] id;
        logic [1:0] prio;
    } iwk_arb_st_t;
    iwk_arb_st_t st, next_st;

    always_comb begin
        next_st = st;
        if (ce) begin
            next_st = '0;
            // Lower value is more urgent; ties go to the lower line
            for (int i = NUM_SRC - 1; i >= 0; i--) begin
                if (req[i] && (!next_st.valid || prio_of(prio_flat, 5'(i)) <= next_st.prio)) begin
                    next_st.valid = 1'b1;
                    next_st.id = 5'(i);
                    next_st.prio = prio_of(prio_flat, 5'(i));
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign best_valid = st.valid;
    assign best_id = st.id;
    assign best_prio = st.prio;

    AST_PRIO_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ce) && best_valid |-> best_prio == prio_of($past(prio_flat), best_id))
        else $error("winner priority differs from its field");
endmodule

// ==== hw/iwk_wake_det.sv ====
// Stop-mode wake detector: gates wake sources and asks for clocks.
// Assumes this logic sits on the always-on clock while core clocks stop.
`timescale 1ns/10ps
module iwk_wake_det (
    // Clock, reset, enable
    input logic aclk,
    input logic aresetn,
    input logic ce,
    // Mode and sources
    input logic stop,
    input logic [17:0] wake_en,
    input iwk_pkg::iwk_wake_src_t src,
    input iwk_pkg::iwk_wake_qual_t qual,
    // Clock control and hand-off
    input logic clk_running,
    input logic taken,
    output logic wake_req,
    output logic cause_valid,
    output logic [17:0] cause
);
    import iwk_pkg::*;
    typedef struct packed {
        iwk_wake_state_t fsm;
        logic req;
        logic [17:0] cause;
    } iwk_wd_st_t;
    iwk_wd_st_t st, next_st;
    logic [17:0] qmask;
    logic [17:0] gated;

    always_comb begin
        qmask = '1;
        qmask[0] = qual.rst_flt_lpo;
        qmask[4] = qual.adc_int_clk;
        qmask[17:10] = qual.per_clk_on;
        // Power monitors, pin interrupts, comparator and clock alarms pass ungated
        gated = src & qmask & wake_en;
    end

    always_comb begin
        next_st = st;
        if (ce) begin
            case (st.fsm)
                WK_IDLE: begin
                    if (stop && gated != 18'h0) begin
                        next_st.fsm = WK_HOLD;
                        next_st.req = 1'b1;
                        next_st.cause = gated;
                    end
                end
                WK_HOLD: begin
                    next_st.cause = st.cause | gated;
                    if (clk_running) begin
                        next_st.fsm = WK_GIVE;
                    end
                end
                WK_GIVE: begin
                    next_st.cause = st.cause | gated;
                    if (taken) begin
                        // Events landing on the hand-off edge start a new round
                        next_st.cause = gated;
                        next_st.fsm = (gated != 18'h0) ? WK_GIVE : WK_IDLE;
                        next_st.req = (gated != 18'h0);
                    end
                end
                default: begin
                    next_st = '0;
                    next_st.fsm = WK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.fsm <= WK_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign wake_req = st.req;
    assign cause_valid = (st.fsm == WK_GIVE);
    assign cause = st.cause;

    AST_STOP_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && stop && gated != 18'h0 && st.fsm == WK_IDLE |=> wake_req && st.fsm == WK_HOLD)
        else $error("stop wake event did not raise wake request");
    AST_HOLD_REQ: assert property (@(posedge aclk) disable iff (!aresetn)
        st.fsm == WK_HOLD |=> wake_req && cause != 18'h0)
        else $error("wake request dropped before hand-off");
    AST_QUAL_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && st.fsm == WK_IDLE && (src & wake_en & qmask) == 18'h0 |=> !wake_req)
        else $error("unclocked source raised a wake request");
endmodule
